// ===== spm_chk.sv
// pin and register port assertions for the serial port block
`timescale 1ns/10ps
module spm_chk
   import spm_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // register port and interrupt
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic int_enable,
   input wire logic irq_req,
   // pins
   input wire logic sck_out,
   input wire logic sck_oe,
   input wire logic mosi_oe,
   input wire logic miso_oe,
   input wire logic slave_select_n_out,
   input wire logic slave_select_n_oe
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);
   sequence sck_edge;
      sck_oe && $past(sck_oe) && $changed(sck_out);
   endsequence
   sequence sck_hold;
      ##1 (!sck_oe || $stable(sck_out));
   endsequence
   chk_sck_half_min: assert property (sck_edge |-> sck_hold)
      else $error("serial clock half period shorter than two cycles");
   chk_irq_gated: assert property (irq_req |-> int_enable)
      else $error("interrupt request without interrupt enable");
   chk_irq_held: assert property (irq_req && !reg_wr |=> irq_req || !int_enable)
      else $error("interrupt flag dropped without software clear");
   chk_master_pins: assert property (sck_oe == mosi_oe)
      else $error("clock and data drivers disagree on master role");
   chk_slave_pins: assert property (miso_oe |-> !sck_oe)
      else $error("slave output driven while acting as master");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   chk_select_out: assert property (slave_select_n_oe && !reg_wr |=> $stable(slave_select_n_out) || !slave_select_n_oe)
      else $error("select output changed without a register write");
   chk_sck_still: assert property (!sck_oe && $past(!sck_oe) && !reg_wr |=> $stable(sck_out))
      else $error("serial clock moved while not master");
endmodule
bind spm_core spm_chk u_chk (.clk_sys, .arst_n, .reg_wr, .reg_rd, .reg_rdata, .int_enable, .irq_req, .sck_out,
   .sck_oe, .mosi_oe, .miso_oe, .slave_select_n_out, .slave_select_n_oe);

// ===== spm_core.sv
// serial peripheral port: master/slave engine, registers and pin control
`timescale 1ns/10ps
module spm_core
   import spm_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // special function register port
   input wire logic [1:0] reg_idx,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // interrupt
   input wire logic int_enable,
   output logic irq_req,
   // serial clock pin
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   // master-out pin
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   // master-in pin
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   // slave select pin
   input wire logic slave_select_n_in,
   output logic slave_select_n_out,
   output logic slave_select_n_oe
);
   typedef enum logic {M_IDLE, M_RUN} spm_mstate_e;

   function automatic logic [8:0] spm_half_len(input logic [7:0] rate);
      logic [8:0] h;
      h = {1'b0, rate} + 9'h001;
      if (h < MIN_HALF) begin
         h = MIN_HALF;
      end
      return h;
   endfunction

   // pin synchronisers {sck, mosi, miso, select}; filter output taken ahead of its hold flop to save a cycle
   logic [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
   logic [3:0] pin_f_d;
   logic sck_f, mosi_f, miso_f, nss_f;

   // register state
   logic master_en_q, phase_q, pol_q, write_collision_enable_q;
   logic done_q, write_collision_flag_q, mode_fault_flag_q, ovrn_q, txempty_q, port_en_q;
   logic [1:0] mode_q;
   logic [7:0] rate_q, txbuf_q, rxbuf_q, sh_q, rdata_q;
   logic rx_full_q, sh_full_q;

   // engine state
   spm_mstate_e mstate_q;
   logic [8:0] half_cnt_q;
   logic [3:0] edge_q;
   logic tog_q, dout_q, cap_q, sck_prev_q, nss_prev_q;
   logic [2:0] bit_cnt_q;

   assign pin_f_d = (~(pin_s2_q ^ pin_s3_q) & pin_s2_q) | ((pin_s2_q ^ pin_s3_q) & pin_f_q);
   assign sck_f = pin_f_d[3];
   assign mosi_f = pin_f_d[2];
   assign miso_f = pin_f_d[1];
   assign nss_f = pin_f_d[0];

   // decode
   logic wr_cfg, wr_ctl, wr_ckr, wr_dat, rd_dat;
   assign wr_cfg = reg_wr & (reg_idx == IDX_CFG);
   assign wr_ctl = reg_wr & (reg_idx == IDX_CTL);
   assign wr_ckr = reg_wr & (reg_idx == IDX_CKR);
   assign wr_dat = reg_wr & (reg_idx == IDX_DAT);
   assign rd_dat = reg_rd & (reg_idx == IDX_DAT);

   // role and selection
   logic slave_sel, sl_act, m_run;
   assign slave_sel = (mode_q == MODE_4WIRE_IN) ? ~nss_f : 1'b1;
   assign sl_act = port_en_q & ~master_en_q & slave_sel;
   assign m_run = (mstate_q == M_RUN);

   // master timing
   logic [8:0] half_len;
   logic m_tick, m_first, m_second, m_done;
   assign half_len = spm_half_len(rate_q);
   assign m_tick = m_run & (half_cnt_q == half_len - 9'h001);
   assign m_first = m_tick & ~edge_q[0];
   assign m_second = m_tick & edge_q[0];
   assign m_done = m_second & (edge_q == 4'hf);

   // slave edges, leading edge leaves the idle level
   logic sck_chg, s_lead, s_trail, s_done, nss_fall;
   assign sck_chg = sl_act & (sck_f != sck_prev_q);
   assign s_lead = sck_chg & (sck_f ^ pol_q);
   assign s_trail = sck_chg & ~(sck_f ^ pol_q);
   assign s_done = s_trail & (bit_cnt_q == 3'h7);
   assign nss_fall = nss_prev_q & ~nss_f & (mode_q == MODE_4WIRE_IN);

   // shifter events
   logic load_sh, m_start, abort, mode_fault_flag_evt, ovrn_evt, write_collision_flag_evt, wr_ok, rx_load;
   logic [7:0] sh_next;
   assign mode_fault_flag_evt = port_en_q & master_en_q & (mode_q == MODE_4WIRE_IN) & ~nss_f;
   assign abort = ~port_en_q | mode_fault_flag_evt;
   assign load_sh = port_en_q & ~txempty_q & ~sh_full_q & (master_en_q ? ~m_run : (bit_cnt_q == 3'h0));
   assign m_start = load_sh & master_en_q;
   // middle of the bit is the first edge for phase 0 and the second for phase 1
   assign sh_next = m_second ? {sh_q[6:0], miso_f} : {sh_q[6:0], (phase_q ? mosi_f : cap_q)};
   assign wr_ok = wr_dat & txempty_q;
   assign write_collision_flag_evt = wr_dat & ~txempty_q & write_collision_enable_q;
   assign ovrn_evt = s_done & rx_full_q;
   assign rx_load = m_done | (s_done & ~rx_full_q);

   // read mux
   logic [7:0] cfg_val, ctl_val, rd_val;
   logic busy, rx_empty;
   assign busy = m_run | (sl_act & (bit_cnt_q != 3'h0));
   assign rx_empty = master_en_q | ~rx_full_q;
   always_comb begin
      cfg_val = 8'h00;
      cfg_val[CFG_BUSY] = busy;
      cfg_val[CFG_MASTER_ENABLE] = master_en_q;
      cfg_val[CFG_PHASE] = phase_q;
      cfg_val[CFG_POL] = pol_q;
      cfg_val[CFG_SELECTED] = ~nss_f;
      cfg_val[CFG_PINRAW] = slave_select_n_in;
      cfg_val[CFG_WCOLEN] = write_collision_enable_q;
      cfg_val[CFG_RXEMPTY] = rx_empty;
      ctl_val = 8'h00;
      ctl_val[CTL_DONE] = done_q;
      ctl_val[CTL_WRITE_COLLISION_FLAG] = write_collision_flag_q;
      ctl_val[CTL_MODE_FAULT_FLAG] = mode_fault_flag_q;
      ctl_val[CTL_OVRN] = ovrn_q;
      ctl_val[CTL_MODE_HI] = mode_q[1];
      ctl_val[CTL_MODE_LO] = mode_q[0];
      ctl_val[CTL_TXEMPTY] = txempty_q;
      ctl_val[CTL_EN] = port_en_q;
   end
   assign rd_val = (reg_idx == IDX_CFG) ? cfg_val :
                   (reg_idx == IDX_CTL) ? ctl_val :
                   (reg_idx == IDX_CKR) ? rate_q : rxbuf_q;

   // flag next values: hardware set beats a software clear in the same cycle
   logic done_d, write_collision_flag_d, mode_fault_flag_d, ovrn_d;
   assign done_d = (m_done | s_done) | (done_q & ~(wr_ctl & ~reg_wdata[CTL_DONE]));
   assign write_collision_flag_d = write_collision_flag_evt | (write_collision_flag_q & ~(wr_ctl & ~reg_wdata[CTL_WRITE_COLLISION_FLAG]));
   assign mode_fault_flag_d = mode_fault_flag_evt | (mode_fault_flag_q & ~(wr_ctl & ~reg_wdata[CTL_MODE_FAULT_FLAG]));
   assign ovrn_d = ovrn_evt | (ovrn_q & ~(wr_ctl & ~reg_wdata[CTL_OVRN]));

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_q <= RST_PINS;
         pin_s2_q <= RST_PINS;
         pin_s3_q <= RST_PINS;
         pin_f_q <= RST_PINS;
      end else begin
         pin_s1_q <= {sck_in, mosi_in, miso_in, slave_select_n_in};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q <= pin_f_d;
      end
   end

   // configuration and control registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         master_en_q <= 1'b0;
         phase_q <= 1'b0;
         pol_q <= 1'b0;
         write_collision_enable_q <= 1'b0;
         mode_q <= RST_MODE;
         port_en_q <= 1'b0;
         rate_q <= RST_BYTE;
      end else begin
         if (wr_cfg) begin
            phase_q <= reg_wdata[CFG_PHASE];
            pol_q <= reg_wdata[CFG_POL];
            write_collision_enable_q <= reg_wdata[CFG_WCOLEN];
         end
         if (wr_ctl) begin
            mode_q <= reg_wdata[CTL_MODE_HI:CTL_MODE_LO];
         end
         if (wr_ckr) begin
            rate_q <= reg_wdata;
         end
         if (mode_fault_flag_evt) begin
            master_en_q <= 1'b0;
            port_en_q <= 1'b0;
         end else begin
            if (wr_cfg) begin
               master_en_q <= reg_wdata[CFG_MASTER_ENABLE];
            end
            if (wr_ctl) begin
               port_en_q <= reg_wdata[CTL_EN];
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         done_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         ovrn_q <= 1'b0;
         rdata_q <= RST_BYTE;
      end else begin
         done_q <= done_d;
         write_collision_flag_q <= write_collision_flag_d;
         mode_fault_flag_q <= mode_fault_flag_d;
         ovrn_q <= ovrn_d;
         if (reg_rd) begin
            rdata_q <= rd_val;
         end
      end
   end

   // transmit and receive buffers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         txbuf_q <= RST_BYTE;
         txempty_q <= 1'b1;
         rxbuf_q <= RST_BYTE;
         rx_full_q <= 1'b0;
      end else begin
         if (wr_ok) begin
            txbuf_q <= reg_wdata;
            txempty_q <= 1'b0;
         end else if (load_sh) begin
            txempty_q <= 1'b1;
         end
         if (rx_load) begin
            rxbuf_q <= sh_next;
         end
         if (s_done & ~rx_full_q) begin
            rx_full_q <= 1'b1;
         end else if (rd_dat | master_en_q) begin
            rx_full_q <= 1'b0;
         end
      end
   end

   // shift register shared by both roles
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sh_q <= RST_BYTE;
         sh_full_q <= 1'b0;
      end else begin
         if (load_sh) begin
            sh_q <= txbuf_q;
            sh_full_q <= 1'b1;
         end else if (m_second | s_trail) begin
            sh_q <= sh_next;
         end
         if (abort | m_done | s_done) begin
            sh_full_q <= 1'b0;
         end
      end
   end

   // master sequencer
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         mstate_q <= M_IDLE;
         half_cnt_q <= 9'h000;
         edge_q <= 4'h0;
         tog_q <= 1'b0;
      end else begin
         case (mstate_q)
            M_IDLE: begin
               half_cnt_q <= 9'h000;
               edge_q <= 4'h0;
               tog_q <= 1'b0;
               if (m_start & ~abort) begin
                  mstate_q <= M_RUN;
               end
            end
            M_RUN: begin
               if (abort) begin
                  mstate_q <= M_IDLE;
                  tog_q <= 1'b0;
               end else if (m_tick) begin
                  half_cnt_q <= 9'h000;
                  edge_q <= edge_q + 4'h1;
                  tog_q <= ~tog_q;
                  if (m_done) begin
                     mstate_q <= M_IDLE;
                  end
               end else begin
                  half_cnt_q <= half_cnt_q + 9'h001;
               end
            end
            default: begin
               mstate_q <= M_IDLE;
            end
         endcase
      end
   end

   // outgoing data bit and slave bit counter
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dout_q <= 1'b0;
         cap_q <= 1'b0;
         bit_cnt_q <= 3'h0;
         sck_prev_q <= 1'b0;
         nss_prev_q <= 1'b1;
      end else begin
         sck_prev_q <= sck_f;
         nss_prev_q <= nss_f;
         // phase 0 presents the bit before the first edge, phase 1 at the first edge
         if (m_start & ~phase_q) begin
            dout_q <= txbuf_q[7];
         end else if (m_second & ~phase_q) begin
            dout_q <= sh_q[6];
         end else if ((m_first | s_lead) & phase_q) begin
            dout_q <= sh_q[7];
         end
         if (s_lead & ~phase_q) begin
            cap_q <= mosi_f;
         end
         if (abort | master_en_q | nss_fall | (mode_q == MODE_4WIRE_IN & nss_f)) begin
            bit_cnt_q <= 3'h0;
         end else if (s_trail) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
      end
   end

   // pin drive
   assign sck_out = pol_q ^ tog_q;
   assign sck_oe = port_en_q & master_en_q;
   assign mosi_out = dout_q;
   assign mosi_oe = port_en_q & master_en_q;
   assign miso_out = phase_q ? dout_q : sh_q[7];
   assign miso_oe = sl_act;
   assign slave_select_n_out = mode_q[0];
   assign slave_select_n_oe = port_en_q & mode_q[1];

   assign reg_rdata = rdata_q;
   assign irq_req = int_enable & (done_q | (write_collision_flag_q & write_collision_enable_q) | mode_fault_flag_q | ovrn_q);
endmodule

// ===== spm_core_test.sv
// self-checking bench for the serial port block
`timescale 1ns/10ps
module spm_core_test;
   import spm_pkg::*;
   logic clk_sys, arst_n, reg_wr, reg_rd, int_enable, tb_sck, tb_mosi, tb_ss, load, pha, pol, sck_prev;
   logic [1:0] reg_idx;
   logic [7:0] reg_wdata, reg_rdata, reply, got, v, s, dat;
   logic irq_req, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, ss_out, ss_oe, peer_miso;
   int mismatches, comparisons, cyc, last, gap;
   // undriven pins fall back to the bench or the peer
   wire sck_w = sck_oe ? sck_out : tb_sck;
   wire mosi_w = mosi_oe ? mosi_out : tb_mosi;
   wire miso_w = miso_oe ? miso_out : peer_miso;
   wire ss_w = ss_oe ? ss_out : tb_ss;
   spm_core dut (.clk_sys, .arst_n, .reg_idx, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .int_enable, .irq_req,
      .sck_in(sck_w), .sck_out, .sck_oe, .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out,
      .miso_oe, .slave_select_n_in(ss_w), .slave_select_n_out(ss_out), .slave_select_n_oe(ss_oe));
   spm_peer peer (.sck(sck_w), .mosi(mosi_w), .miso(peer_miso), .pha, .pol, .load, .reply, .got);
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task give_verdict;
      $display("compared %0d, mismatched %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // keep leaves the strobe up so the next write lands on the very next edge
   task wr(input logic [1:0] i, input logic [7:0] d, input bit keep = 1'b0);
      @(posedge clk_sys);
      #2 reg_rd = 1'b0;
      reg_wr = 1'b1;
      reg_idx = i;
      reg_wdata = d;
      if (!keep) begin
         @(posedge clk_sys);
         #2 reg_wr = 1'b0;
      end
   endtask
   task rd(input logic [1:0] i, output logic [7:0] d);
      @(posedge clk_sys);
      #2 reg_wr = 1'b0;
      reg_rd = 1'b1;
      reg_idx = i;
      @(posedge clk_sys);
      #2 reg_rd = 1'b0;
      d = reg_rdata;
   endtask
   task wait_done;
      for (int n = 0; n < 300; n++) begin
         rd(IDX_CTL, v);
         if (v[CTL_DONE] === 1'b1) return;
      end
      chk("done wait", 8'h01, 8'h00);
   endtask
   // bit period of 12 clocks keeps within a tenth of the system clock
   task xfer(input logic [7:0] m, output logic [7:0] r);
      for (int b = 7; b >= 0; b--) begin
         tb_mosi = m[b];
         repeat (6) @(posedge clk_sys);
         #2 r[b] = miso_w;
         tb_sck = 1'b1;
         repeat (6) @(posedge clk_sys);
         #2 tb_sck = 1'b0;
      end
      repeat (8) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (sck_oe === 1'b1 && sck_out !== sck_prev) begin
         gap = cyc - last;
         last = cyc;
      end
      sck_prev = sck_out;
   end
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #1_000_000;
      mismatches++;
      give_verdict();
   end
   initial begin
      {arst_n, reg_idx, reg_wr, reg_rd, reg_wdata, tb_sck, tb_mosi, load, reply, pha, pol} = '0;
      int_enable = 1'b1;
      tb_ss = 1'b1;
      void'($urandom(32'h4913957b));
      repeat (12) @(posedge clk_sys);
      #2 arst_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      rd(IDX_CFG, v);
      chk("cfg reset", 8'h05, v);
      rd(IDX_CTL, v);
      chk("ctl reset", 8'h06, v);
      rd(IDX_CKR, v);
      chk("rate reset", 8'h00, v);
      // phase 1 returns its bit one half period before the sample, so that half needs four clocks for the synchroniser
      for (int i = 0; i < 4; i++) begin
         {pha, pol} = 2'(i);
         dat = 8'($urandom);
         reply = 8'($urandom);
         wr(IDX_CKR, 8'(i < 2 ? i : i + 1));
         wr(IDX_CFG, {1'b0, 1'b1, pha, pol, 2'b00, i != 3, 1'b0});
         wr(IDX_CTL, 8'h01);
         load = 1'b1;
         #1 load = 1'b0;
         chk("idle clock", {7'h0, pol}, {7'h0, sck_out});
         wr(IDX_DAT, dat, 1'b1);
         wr(IDX_DAT, ~dat);
         rd(IDX_CFG, v);
         chk("busy", 8'h01, {7'h0, v[CFG_BUSY]});
         wait_done();
         chk("sent", dat, got);
         chk("half period", 8'(i < 2 ? 2 : i + 2), 8'(gap));
         chk("end clock", {7'h0, pol}, {7'h0, sck_out});
         rd(IDX_CTL, v);
         chk("ctl done", {1'b1, i != 3, 6'h03}, v);
         chk("irq", 8'h01, {7'h0, irq_req});
         rd(IDX_DAT, v);
         chk("received", reply, v);
         rd(IDX_CFG, v);
         chk("cfg idle", {2'b01, pha, pol, 2'b01, i != 3, 1'b1}, v);
         wr(IDX_CTL, 8'h00);
         chk("irq clear", 8'h00, {7'h0, irq_req});
      end
      // select pin driven from the mode field, low then high, then released with the port off
      wr(IDX_CTL, 8'h09);
      chk("select low", 8'h00, {7'h0, ss_w});
      rd(IDX_CFG, v);
      chk("select pin", 8'h00, {7'h0, v[CFG_PINRAW]});
      wr(IDX_CTL, 8'h0d);
      chk("select high", 8'h01, {7'h0, ss_w});
      wr(IDX_CTL, 8'h0c);
      chk("select off", 8'h00, {7'h0, ss_oe});
      {pha, pol} = 2'b00;
      wr(IDX_CFG, 8'h40);
      wr(IDX_CTL, 8'h05);
      tb_ss = 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(IDX_CTL, v);
      chk("mode fault", 8'h26, v);
      rd(IDX_CFG, v);
      chk("role after fault", 8'h09, v);
      @(posedge clk_sys);
      #2 int_enable = 1'b0;
      #1 chk("irq masked", 8'h00, {7'h0, irq_req});
      @(posedge clk_sys);
      #2 int_enable = 1'b1;
      wr(IDX_CTL, 8'h05);
      dat = 8'($urandom);
      wr(IDX_DAT, dat);
      xfer(8'ha5, s);
      chk("slave out", dat, s);
      rd(IDX_CFG, v);
      chk("slave rx", 8'h08, v);
      xfer(8'($urandom), s);
      rd(IDX_CTL, v);
      chk("overrun", 8'h97, v);
      rd(IDX_DAT, v);
      chk("kept byte", 8'ha5, v);
      rd(IDX_CFG, v);
      chk("rx read", 8'h09, v);
      give_verdict();
   end
endmodule

// ===== spm_peer.sv
// behavioural far-end serial slave: captures the incoming byte, returns a reply
`timescale 1ns/10ps
module spm_peer (
   // serial lines
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   // settings and data
   input wire logic pha,
   input wire logic pol,
   input wire logic load,
   input wire logic [7:0] reply,
   output logic [7:0] got
);
   logic [7:0] sh_q;
   initial begin
      miso = 1'b0;
      got = 8'h00;
      sh_q = 8'h00;
   end
   always @(posedge load) begin
      sh_q = reply;
      miso = reply[7];
   end
   // same phase and polarity as the device; idle clock moves must precede load
   always @(sck) begin
      if ((sck !== pol) !== pha) begin
         got = {got[6:0], mosi};
      end else begin
         miso = pha ? sh_q[7] : sh_q[6];
         sh_q = {sh_q[6:0], ~sh_q[0]};
      end
   end
endmodule

// ===== spm_pkg.sv
// constants and register layout for the serial port block
// Behaviour
// - set byte_done_flag after every byte in every mode; interrupt when enabled
// - data write while transmit buffer full sets collision flag, byte discarded
// - write_collision_enable low: collision flag never sets nor interrupts
// - master in select mode 01 with select low: mode fault, clear master/port enable
// - slave byte done with unread receive byte: overrun, keep old, drop new
// - the four flags stay set until software clears them
// - clock_phase picks data centred on first or second serial clock edge
// - clock_polarity sets serial clock idle level low or high
// - master serial clock is system clock over 2*(rate+1), half period at least 2 clocks; slave ignores rate
// - master never shifts faster than a quarter of the system clock or 12.5 MHz
// - slave samples input mid-bit; master samples in last clock of each bit
// - transfer_busy reads 1 while the master runs, or in slave role from the end of the first bit to the end of the byte
// - master_enable 0 selects slave role, 1 selects master role
// - selected_status reads de-glitched select pin, 1 while low
// - select_pin_raw reads the raw select pin level
// - receive_empty 1 when nothing unread; always 1 in master mode
// - select mode 00 unused, 01 input, 1x output driven with low bit
// - transmit_empty clears on buffer write, sets when byte moves to shifter
// - port_enable turns the whole interface off or on
// - data write fills transmit buffer and starts master; read returns receive buffer
// - full duplex, most significant bit first in both directions
// - 4-wire slave resets bit counter on select falling edge
package spm_pkg;
   // register indices on the special function register port
   localparam logic [1:0] IDX_CFG = 2'h0;
   localparam logic [1:0] IDX_CTL = 2'h1;
   localparam logic [1:0] IDX_CKR = 2'h2;
   localparam logic [1:0] IDX_DAT = 2'h3;
   // config register bits
   localparam int CFG_BUSY = 7;
   localparam int CFG_MASTER_ENABLE = 6;
   localparam int CFG_PHASE = 5;
   localparam int CFG_POL = 4;
   localparam int CFG_SELECTED = 3;
   localparam int CFG_PINRAW = 2;
   localparam int CFG_WCOLEN = 1;
   localparam int CFG_RXEMPTY = 0;
   // control register bits
   localparam int CTL_DONE = 7;
   localparam int CTL_WRITE_COLLISION_FLAG = 6;
   localparam int CTL_MODE_FAULT_FLAG = 5;
   localparam int CTL_OVRN = 4;
   localparam int CTL_MODE_HI = 3;
   localparam int CTL_MODE_LO = 2;
   localparam int CTL_TXEMPTY = 1;
   localparam int CTL_EN = 0;
   // select modes
   localparam logic [1:0] MODE_3WIRE = 2'h0;
   localparam logic [1:0] MODE_4WIRE_IN = 2'h1;
   // reset values
   localparam logic [1:0] RST_MODE = 2'h1;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_PINS = 4'h1;
   // timing
   localparam int CLK_HZ = 50_000_000;
   localparam int SCK_MAX_HZ = 12_500_000;
   localparam int MIN_HALF_INT = (CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ);
   localparam logic [8:0] MIN_HALF = 9'(MIN_HALF_INT);
endpackage
